// File: hdl/cvrc_params.svh
// register indices, field positions, reset values and timing counts
`ifndef CVRC_PARAMS_SVH
`define CVRC_PARAMS_SVH
// ----------------------------------------
// register indices carried in the command byte
// ----------------------------------------
`define CVRC_IDX_CHANNEL_CTRL 4'h1
`define CVRC_IDX_RX_BYTE 4'h2
`define CVRC_IDX_TX_BYTE 4'h3
`define CVRC_IDX_ROUTING 4'h4
`define CVRC_IDX_TX_GAIN 4'h5
`define CVRC_IDX_RX_GAIN 4'h6
`define CVRC_IDX_GEN_CTRL 4'h7
`define CVRC_IDX_GEN_A_FREQ 4'h8
`define CVRC_IDX_GEN_B_FREQ 4'h9
// ----------------------------------------
// command byte layout
// ----------------------------------------
`define CVRC_CMD_IDX_MSB 7
`define CVRC_CMD_IDX_LSB 4
`define CVRC_CMD_READ_BIT 3
// ----------------------------------------
// channel_ctrl_reg fields
// ----------------------------------------
`define CVRC_HOST_RX_OVERRIDE 4
`define CVRC_HOST_TX_OVERRIDE 3
`define CVRC_VOICE_SLOT_GATE 2
`define CVRC_SLOT_PICK_HI 1
`define CVRC_SLOT_PICK_LO 0
// ----------------------------------------
// routing_reg fields
// ----------------------------------------
`define CVRC_MIC_CHOICE 7
`define CVRC_TX_INPUT_ON 6
`define CVRC_LOCAL_ECHO_ON 5
`define CVRC_AUX_TO_LOUDSPKR 4
`define CVRC_GEN_TO_LOUDSPKR 3
`define CVRC_GEN_TO_EARPC 2
`define CVRC_RX_TO_LOUDSPKR 1
`define CVRC_RX_TO_EARPC 0
// ----------------------------------------
// gen_ctrl_reg fields
// ----------------------------------------
`define CVRC_GEN_A_PICK 3
`define CVRC_GEN_B_PICK 2
`define CVRC_WAVE_SHAPE 1
`define CVRC_GEN_TO_TX_STREAM 0
// ----------------------------------------
// reset values and pcm slot layout
// ----------------------------------------
`define CVRC_REG_RESET 8'h00
`define CVRC_SLOT_BITS 8'h08
`define CVRC_FMT2_GAP 8'h02
// ----------------------------------------
// generator timing: step = sample rate / 2**phase width = 7.8125 Hz
// ----------------------------------------
`define CVRC_CLK_HZ 10000000
`define CVRC_SAMPLE_HZ 8000
`define CVRC_SAMPLE_DIV (`CVRC_CLK_HZ / `CVRC_SAMPLE_HZ)
`define CVRC_PHASE_W 10
`endif

// File: hdl/cvrc_pkg.sv
// types shared by the voice routing control block
package cvrc_pkg;
    typedef enum logic [1:0] {CTL_CMD, CTL_RDATA, CTL_WDATA, CTL_DONE} cvrc_ctl_state_t;
    typedef logic [7:0] cvrc_byte_t;
endpackage

// File: hdl/cvrc_top.sv
// voice codec control registers, serial control port, pcm slot access and tone generator
// Functional notes
// - host rx override decodes host byte each frame
// - rx_byte_reg read gives last received byte
// - host tx override sends tx_byte_reg each frame
// - slot gate off: no decode, output released
// - gci mode: two bits pick channel
// - pcm mode: high pick bit ignored
// - mic choice and transmit input enable
// - sidetone enable, forced off when tx off
// - aux input to loudspeaker switch
// - generator to loudspeaker and earpiece independently
// - received speech to loudspeaker and earpiece
// - transmit gain code, upper nibble
// - sidetone attenuation code, lower nibble
// - earpiece gain code, upper nibble
// - loudspeaker gain code, lower nibble
// - generator attenuation code, upper nibble
// - two picks select generator frequencies
// - wave shape selects sine or square
// - generator replaces transmit amplifier output
// - frequency proportional to eight bit code
`timescale 1ns/1ns
`default_nettype none
`include "cvrc_params.svh"
module cvrc_top
    import cvrc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic ctl_cs_n,
    input wire logic ctl_clk,
    input wire logic ctl_din,
    output logic ctl_dout,
    output logic ctl_dout_oe,
    input wire logic gci_mode,
    input wire logic pcm_format2,
    input wire logic pcm_bclk,
    input wire logic pcm_fs,
    input wire logic pcm_in_pin,
    output logic pcm_out_pin,
    output logic pcm_out_oe,
    input wire logic [7:0] enc_byte,
    output logic [7:0] dec_byte,
    output logic dec_valid,
    input wire logic dec_ready,
    output logic mic_sel_b,
    output logic tx_input_en,
    output logic sidetone_en,
    output logic aux_to_ls,
    output logic gen_to_ls,
    output logic gen_to_ep,
    output logic rx_to_ls,
    output logic rx_to_ep,
    output logic [3:0] tx_gain_code,
    output logic [3:0] sidetone_att_code,
    output logic [3:0] ep_gain_code,
    output logic [3:0] ls_gain_code,
    output logic [3:0] gen_att_code,
    output logic gen_a_en,
    output logic gen_b_en,
    output logic gen_sine,
    output logic gen_to_tx,
    output logic [9:0] gen_a_phase,
    output logic [9:0] gen_b_phase
);
    // ----------------------------------------
    // reset release and pin synchronisers
    // ----------------------------------------
    logic [1:0] rst_sync_ff;
    logic rst_n;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    logic [6:0] pin_s1_ff;
    logic [6:0] pin_s2_ff;
    logic ctl_clk_prev_ff;
    logic bclk_prev_ff;
    logic fs_prev_ff;
    logic ctl_clk_s;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_ff <= 7'h01;
            pin_s2_ff <= 7'h01;
            ctl_clk_prev_ff <= 1'b0;
            bclk_prev_ff <= 1'b0;
            fs_prev_ff <= 1'b0;
        end else begin
            pin_s1_ff <= {pcm_format2, gci_mode, pcm_in_pin, pcm_fs, pcm_bclk, ctl_din, ctl_cs_n};
            pin_s2_ff <= pin_s1_ff;
            ctl_clk_prev_ff <= ctl_clk_s;
            bclk_prev_ff <= pin_s2_ff[2];
            fs_prev_ff <= pin_s2_ff[3];
        end
    end
    logic cs_n_s;
    logic din_s;
    logic [1:0] ctl_clk_sync_ff;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctl_clk_sync_ff <= 2'h0;
        end else begin
            ctl_clk_sync_ff <= {ctl_clk_sync_ff[0], ctl_clk};
        end
    end
    assign ctl_clk_s = ctl_clk_sync_ff[1];
    assign cs_n_s = pin_s2_ff[0];
    assign din_s = pin_s2_ff[1];
    logic ctl_rise;
    logic ctl_fall;
    assign ctl_rise = ctl_clk_s && !ctl_clk_prev_ff && !cs_n_s;
    assign ctl_fall = !ctl_clk_s && ctl_clk_prev_ff && !cs_n_s;

    // ----------------------------------------
    // serial control port
    // ----------------------------------------
    cvrc_ctl_state_t ctl_state_ff;
    logic [2:0] ctl_bit_ff;
    logic [6:0] ctl_sh_ff;
    logic [3:0] ctl_idx_ff;
    logic [7:0] ctl_out_sh_ff;
    logic ctl_dout_ff;
    logic wr_en;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic [7:0] cmd_byte;
    assign cmd_byte = {ctl_sh_ff, din_s};
    assign wr_data = {ctl_sh_ff, din_s};
    // the second byte of a write commits on its eighth rising edge
    assign wr_en = ctl_rise && (ctl_bit_ff == 3'h7) && (ctl_state_ff == CTL_WDATA);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctl_state_ff <= CTL_CMD;
            ctl_bit_ff <= 3'h0;
            ctl_sh_ff <= 7'h00;
            ctl_idx_ff <= 4'h0;
        end else if (cs_n_s) begin
            ctl_state_ff <= CTL_CMD;
            ctl_bit_ff <= 3'h0;
        end else if (ctl_rise) begin
            ctl_sh_ff <= cmd_byte[6:0];
            ctl_bit_ff <= ctl_bit_ff + 3'h1;
            if (ctl_bit_ff == 3'h7) begin
                case (ctl_state_ff)
                    CTL_CMD: begin
                        ctl_idx_ff <= cmd_byte[`CVRC_CMD_IDX_MSB:`CVRC_CMD_IDX_LSB];
                        ctl_state_ff <= cmd_byte[`CVRC_CMD_READ_BIT] ? CTL_RDATA : CTL_WDATA;
                    end
                    default: ctl_state_ff <= CTL_DONE;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctl_out_sh_ff <= 8'h00;
            ctl_dout_ff <= 1'b0;
        end else if (ctl_rise && ctl_bit_ff == 3'h7 && ctl_state_ff == CTL_CMD) begin
            ctl_dout_ff <= rd_data[7];
            ctl_out_sh_ff <= {rd_data[6:0], 1'b0};
        end else if (ctl_fall && ctl_state_ff == CTL_RDATA && ctl_bit_ff != 3'h0) begin
            ctl_dout_ff <= ctl_out_sh_ff[7];
            ctl_out_sh_ff <= {ctl_out_sh_ff[6:0], 1'b0};
        end
    end
    assign ctl_dout = ctl_dout_ff;
    assign ctl_dout_oe = (ctl_state_ff == CTL_RDATA) && !cs_n_s;

    // ----------------------------------------
    // register file
    // ----------------------------------------
    logic [7:0] chan_ff;
    logic [7:0] host_rx_ff;
    logic [7:0] tx_byte_ff;
    logic [7:0] route_ff;
    logic [7:0] tx_gain_ff;
    logic [7:0] rx_gain_ff;
    logic [7:0] gen_ctrl_ff;
    logic [7:0] gen_a_freq_ff;
    logic [7:0] gen_b_freq_ff;
    logic [7:0] rx_capt_ff;
    logic [3:0] cmd_idx;
    assign cmd_idx = cmd_byte[`CVRC_CMD_IDX_MSB:`CVRC_CMD_IDX_LSB];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            chan_ff <= `CVRC_REG_RESET;
            host_rx_ff <= `CVRC_REG_RESET;
            tx_byte_ff <= `CVRC_REG_RESET;
            route_ff <= `CVRC_REG_RESET;
            tx_gain_ff <= `CVRC_REG_RESET;
            rx_gain_ff <= `CVRC_REG_RESET;
            gen_ctrl_ff <= `CVRC_REG_RESET;
            gen_a_freq_ff <= `CVRC_REG_RESET;
            gen_b_freq_ff <= `CVRC_REG_RESET;
        end else if (wr_en) begin
            case (ctl_idx_ff)
                `CVRC_IDX_CHANNEL_CTRL: chan_ff <= wr_data;
                `CVRC_IDX_RX_BYTE: host_rx_ff <= wr_data;
                `CVRC_IDX_TX_BYTE: tx_byte_ff <= wr_data;
                `CVRC_IDX_ROUTING: route_ff <= wr_data;
                `CVRC_IDX_TX_GAIN: tx_gain_ff <= wr_data;
                `CVRC_IDX_RX_GAIN: rx_gain_ff <= wr_data;
                `CVRC_IDX_GEN_CTRL: gen_ctrl_ff <= wr_data;
                `CVRC_IDX_GEN_A_FREQ: gen_a_freq_ff <= wr_data;
                `CVRC_IDX_GEN_B_FREQ: gen_b_freq_ff <= wr_data;
                default: ;
            endcase
        end
    end

    // read selected from the command index; write-only and unmapped read zero
    always_comb begin
        case (cmd_idx)
            `CVRC_IDX_CHANNEL_CTRL: rd_data = chan_ff;
            `CVRC_IDX_RX_BYTE: rd_data = rx_capt_ff;
            `CVRC_IDX_ROUTING: rd_data = route_ff;
            `CVRC_IDX_TX_GAIN: rd_data = tx_gain_ff;
            `CVRC_IDX_RX_GAIN: rd_data = rx_gain_ff;
            `CVRC_IDX_GEN_CTRL: rd_data = gen_ctrl_ff;
            `CVRC_IDX_GEN_A_FREQ: rd_data = gen_a_freq_ff;
            `CVRC_IDX_GEN_B_FREQ: rd_data = gen_b_freq_ff;
            default: rd_data = 8'h00;
        endcase
    end

    // ----------------------------------------
    // analog switch and gain controls
    // ----------------------------------------
    assign mic_sel_b = route_ff[`CVRC_MIC_CHOICE];
    assign tx_input_en = route_ff[`CVRC_TX_INPUT_ON];
    assign sidetone_en = route_ff[`CVRC_LOCAL_ECHO_ON] && route_ff[`CVRC_TX_INPUT_ON];
    assign aux_to_ls = route_ff[`CVRC_AUX_TO_LOUDSPKR];
    assign gen_to_ls = route_ff[`CVRC_GEN_TO_LOUDSPKR];
    assign gen_to_ep = route_ff[`CVRC_GEN_TO_EARPC];
    assign rx_to_ls = route_ff[`CVRC_RX_TO_LOUDSPKR];
    assign rx_to_ep = route_ff[`CVRC_RX_TO_EARPC];
    assign tx_gain_code = tx_gain_ff[7:4];
    assign sidetone_att_code = tx_gain_ff[3:0];
    assign ep_gain_code = rx_gain_ff[7:4];
    assign ls_gain_code = rx_gain_ff[3:0];
    assign gen_att_code = gen_ctrl_ff[7:4];
    assign gen_a_en = gen_ctrl_ff[`CVRC_GEN_A_PICK];
    assign gen_b_en = gen_ctrl_ff[`CVRC_GEN_B_PICK];
    assign gen_sine = gen_ctrl_ff[`CVRC_WAVE_SHAPE];
    assign gen_to_tx = gen_ctrl_ff[`CVRC_GEN_TO_TX_STREAM];

    // ----------------------------------------
    // tone generator phase accumulators
    // ----------------------------------------
    localparam int SAMPLE_DIV = `CVRC_SAMPLE_DIV;
    logic [10:0] div_ff;
    logic sample_tick;
    logic [9:0] phase_a_ff;
    logic [9:0] phase_b_ff;
    assign sample_tick = (div_ff == 11'(SAMPLE_DIV - 1));
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_ff <= 11'h000;
        end else begin
            div_ff <= sample_tick ? 11'h000 : div_ff + 11'h001;
        end
    end
    // 8 kHz step over a 1024-count wheel gives code x 7.8125 Hz
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            phase_a_ff <= 10'h000;
            phase_b_ff <= 10'h000;
        end else if (sample_tick) begin
            phase_a_ff <= gen_a_en ? phase_a_ff + {2'h0, gen_a_freq_ff} : 10'h000;
            phase_b_ff <= gen_b_en ? phase_b_ff + {2'h0, gen_b_freq_ff} : 10'h000;
        end
    end
    assign gen_a_phase = phase_a_ff;
    assign gen_b_phase = phase_b_ff;

    // ----------------------------------------
    // pcm frame counter and slot selection
    // ----------------------------------------
    logic bclk_rise;
    logic bclk_fall;
    logic frame_start;
    logic [7:0] bit_cnt_ff;
    logic [7:0] slot_start;
    logic in_slot;
    logic slot_last;
    logic gate_on;
    assign bclk_rise = pin_s2_ff[2] && !bclk_prev_ff;
    assign bclk_fall = !pin_s2_ff[2] && bclk_prev_ff;
    assign frame_start = bclk_rise && pin_s2_ff[3] && !fs_prev_ff;
    assign gate_on = chan_ff[`CVRC_VOICE_SLOT_GATE];
    always_comb begin
        if (pin_s2_ff[5]) begin
            slot_start = {4'h0, chan_ff[`CVRC_SLOT_PICK_HI], chan_ff[`CVRC_SLOT_PICK_LO], 2'h0}
                         * `CVRC_SLOT_BITS / 8'h04;
        end else if (chan_ff[`CVRC_SLOT_PICK_LO]) begin
            slot_start = pin_s2_ff[6] ? `CVRC_SLOT_BITS + `CVRC_FMT2_GAP : `CVRC_SLOT_BITS;
        end else begin
            slot_start = 8'h00;
        end
    end
    assign in_slot = (bit_cnt_ff >= slot_start) && (bit_cnt_ff < slot_start + `CVRC_SLOT_BITS);
    assign slot_last = (bit_cnt_ff == slot_start + `CVRC_SLOT_BITS - 8'h01);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_ff <= 8'hff;
        end else if (frame_start) begin
            bit_cnt_ff <= 8'h00;
        end else if (bclk_rise && bit_cnt_ff != 8'hff) begin
            bit_cnt_ff <= bit_cnt_ff + 8'h01;
        end
    end

    // ----------------------------------------
    // transmit slot
    // ----------------------------------------
    logic [7:0] tx_sh_ff;
    logic tx_oe_ff;
    logic [7:0] tx_src;
    logic [7:0] nxt_cnt;
    assign nxt_cnt = frame_start ? 8'h00 : bit_cnt_ff + 8'h01;
    assign tx_src = chan_ff[`CVRC_HOST_TX_OVERRIDE] ? tx_byte_ff : enc_byte;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_sh_ff <= 8'h00;
            tx_oe_ff <= 1'b0;
        end else if (bclk_rise) begin
            if (nxt_cnt == slot_start) begin
                tx_sh_ff <= tx_src;
            end else begin
                tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
            end
            tx_oe_ff <= gate_on && (nxt_cnt >= slot_start) && (nxt_cnt < slot_start + `CVRC_SLOT_BITS);
        end
    end
    assign pcm_out_pin = tx_sh_ff[7];
    assign pcm_out_oe = tx_oe_ff && gate_on;

    // ----------------------------------------
    // receive slot capture
    // ----------------------------------------
    logic [6:0] rx_sh_ff;
    logic [7:0] rx_full_byte;
    logic push;
    logic [7:0] push_data;
    logic buf_in_ready;
    assign rx_full_byte = {rx_sh_ff, pin_s2_ff[4]};
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_sh_ff <= 7'h00;
            rx_capt_ff <= 8'h00;
        end else if (bclk_fall && in_slot) begin
            rx_sh_ff <= rx_full_byte[6:0];
            if (slot_last) begin
                rx_capt_ff <= rx_full_byte;
            end
        end
    end
    assign push = bclk_fall && slot_last && gate_on && buf_in_ready;
    assign push_data = chan_ff[`CVRC_HOST_RX_OVERRIDE] ? host_rx_ff : rx_full_byte;

    // ----------------------------------------
    // two-entry decoder buffer
    // ----------------------------------------
    logic [7:0] buf_mem [0:1];
    logic buf_wp_ff;
    logic buf_rp_ff;
    logic [1:0] buf_cnt_ff;
    logic pop;
    assign buf_in_ready = (buf_cnt_ff != 2'h2);
    assign dec_valid = (buf_cnt_ff != 2'h0);
    assign pop = dec_valid && dec_ready;
    assign dec_byte = buf_mem[buf_rp_ff];
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            buf_mem[0] <= 8'h00;
            buf_mem[1] <= 8'h00;
            buf_wp_ff <= 1'b0;
        end else if (push) begin
            buf_mem[buf_wp_ff] <= push_data;
            buf_wp_ff <= !buf_wp_ff;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            buf_rp_ff <= 1'b0;
            buf_cnt_ff <= 2'h0;
        end else begin
            if (pop) begin
                buf_rp_ff <= !buf_rp_ff;
            end
            buf_cnt_ff <= buf_cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_rx_override;
        @(posedge clk_sys) disable iff (!rst_n)
        push && chan_ff[`CVRC_HOST_RX_OVERRIDE] |=> buf_mem[$past(buf_wp_ff)] == $past(host_rx_ff);
    endproperty
    a_rx_override: assert property (p_rx_override) else $error("override byte not queued");

    property p_rx_capture;
        @(posedge clk_sys) disable iff (!rst_n)
        bclk_fall && in_slot && slot_last |=> rx_capt_ff == $past(rx_full_byte);
    endproperty
    a_rx_capture: assert property (p_rx_capture) else $error("received byte not captured");

    property p_tx_override;
        @(posedge clk_sys) disable iff (!rst_n)
        bclk_rise && nxt_cnt == slot_start && chan_ff[`CVRC_HOST_TX_OVERRIDE] |=> tx_sh_ff == $past(tx_byte_ff);
    endproperty
    a_tx_override: assert property (p_tx_override) else $error("tx byte not loaded");

    property p_gate_off;
        @(posedge clk_sys) disable iff (!rst_n)
        !gate_on |-> !pcm_out_oe && !push;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("slot active while gated");

    property p_pcm_slot;
        @(posedge clk_sys) disable iff (!rst_n)
        !pin_s2_ff[5] |-> slot_start == 8'h00 || slot_start == 8'h08 || slot_start == 8'h0a;
    endproperty
    a_pcm_slot: assert property (p_pcm_slot) else $error("bad pcm slot start");

    property p_sidetone;
        @(posedge clk_sys) disable iff (!rst_n)
        sidetone_en |-> tx_input_en && route_ff[`CVRC_LOCAL_ECHO_ON];
    endproperty
    a_sidetone: assert property (p_sidetone) else $error("sidetone on with tx muted");

    property p_route_write;
        @(posedge clk_sys) disable iff (!rst_n)
        wr_en && ctl_idx_ff == `CVRC_IDX_ROUTING |=> {mic_sel_b, tx_input_en, aux_to_ls, rx_to_ep} ==
            {$past(wr_data[7]), $past(wr_data[6]), $past(wr_data[4]), $past(wr_data[0])};
    endproperty
    a_route_write: assert property (p_route_write) else $error("routing write lost");

    property p_phase_step;
        @(posedge clk_sys) disable iff (!rst_n)
        sample_tick && gen_a_en |=> phase_a_ff == 10'($past(phase_a_ff) + {2'h0, $past(gen_a_freq_ff)});
    endproperty
    a_phase_step: assert property (p_phase_step) else $error("phase step wrong");

    property p_tick_spacing;
        @(posedge clk_sys) disable iff (!rst_n)
        sample_tick |=> !sample_tick [*8];
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("sample tick too close");

    property p_buf_bound;
        @(posedge clk_sys) disable iff (!rst_n)
        buf_cnt_ff == 2'h2 && !pop |=> buf_cnt_ff == 2'h2 && $stable(buf_wp_ff);
    endproperty
    a_buf_bound: assert property (p_buf_bound) else $error("buffer overran");
endmodule
`default_nettype wire

// File: verif/cvrc_pcm_far.sv
// far-side pcm bus controller: bit clock, frame sync, receive slot source, transmit slot capture
`timescale 1ns/1ns
`default_nettype none
module cvrc_pcm_far (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] slot_start,
    input wire logic [7:0] tx_word,
    input wire logic dout,
    input wire logic oe,
    output logic bclk,
    output logic fs,
    output logic din,
    output logic [7:0] rx_word
);
    logic [7:0] cnt;
    logic [7:0] d_tx;
    logic [7:0] d_rx;
    // 32 bits of 8 clocks a frame; bit number in cnt[7:3]
    assign d_tx = {3'h0, cnt[7:3] + 5'h01} - slot_start;
    assign d_rx = {3'h0, cnt[7:3]} - slot_start;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 8'h00;
            bclk <= 1'b0;
            fs <= 1'b0;
            din <= 1'b0;
            rx_word <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
            if (cnt[2:0] == 3'h7) begin
                bclk <= 1'b1;
                fs <= (cnt == 8'hff);
                // outside the slot the line toggles every bit
                din <= (d_tx < 8'h08) ? tx_word[3'h7 - d_tx[2:0]] : ~din;
            end
            if (cnt[2:0] == 3'h3) begin
                bclk <= 1'b0;
            end
            if (cnt[2:0] == 3'h6 && oe && d_rx < 8'h08) begin
                rx_word[3'h7 - d_rx[2:0]] <= dout;
            end
        end
    end
endmodule
`default_nettype wire

// File: verif/cvrc_top_tb.sv
// self-checking bench for the voice routing control block
`timescale 1ns/1ns
`default_nettype none
`include "cvrc_params.svh"
module cvrc_top_tb;
    import cvrc_pkg::*;
    logic clk_sys = 0, reset_n = 0, cs_n = 1, cclk = 0, cdin = 0, gci = 0, fmt2 = 0, rdy = 1, oe_seen = 0;
    logic [7:0] enc = 0, fword = 8'ha5, slot = 0, last_dec = 0, rv, dbyte, rxw;
    logic bclk, fs, din, dout, dout_oe, pout, poe, dval, mic, txe, ste, aux, gls, gep, rls, rep, gae, gbe, sine, g2t;
    logic [3:0] tg, sa, eg, lg, ga;
    logic [9:0] pa, pb, p0, p1;
    int num_errors = 0, checked = 0, cyc = 0;
    always #50 clk_sys = ~clk_sys;
    cvrc_top dut (.clk_sys(clk_sys), .reset_n(reset_n), .ctl_cs_n(cs_n), .ctl_clk(cclk), .ctl_din(cdin),
        .ctl_dout(dout), .ctl_dout_oe(dout_oe), .gci_mode(gci), .pcm_format2(fmt2), .pcm_bclk(bclk),
        .pcm_fs(fs), .pcm_in_pin(din), .pcm_out_pin(pout), .pcm_out_oe(poe), .enc_byte(enc),
        .dec_byte(dbyte), .dec_valid(dval), .dec_ready(rdy), .mic_sel_b(mic), .tx_input_en(txe),
        .sidetone_en(ste), .aux_to_ls(aux), .gen_to_ls(gls), .gen_to_ep(gep), .rx_to_ls(rls), .rx_to_ep(rep),
        .tx_gain_code(tg), .sidetone_att_code(sa), .ep_gain_code(eg), .ls_gain_code(lg), .gen_att_code(ga),
        .gen_a_en(gae), .gen_b_en(gbe), .gen_sine(sine), .gen_to_tx(g2t), .gen_a_phase(pa), .gen_b_phase(pb));
    cvrc_pcm_far far (.clk_sys(clk_sys), .reset_n(reset_n), .slot_start(slot), .tx_word(fword),
        .dout(pout), .oe(poe), .bclk(bclk), .fs(fs), .din(din), .rx_word(rxw));
    always @(posedge clk_sys) if (dval === 1'b1 && rdy === 1'b1) last_dec <= dbyte;
    always @(posedge clk_sys) if (poe === 1'b1) oe_seen <= 1'b1;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // ----------------------------------------
    // two-byte control instruction, msb first
    // ----------------------------------------
    task xfer(input logic [7:0] cmd, input logic [7:0] wd);
        cs_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        for (int i = 0; i < 16; i++) begin
            cdin <= (i < 8) ? cmd[7 - i] : wd[15 - i];
            cclk <= 1'b0;
            repeat (4) @(posedge clk_sys);
            cclk <= 1'b1;
            repeat (4) @(posedge clk_sys);
            if (i >= 8) rv[15 - i] = dout;
        end
        cclk <= 1'b0;
        cs_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
    endtask
    task wr(input logic [3:0] idx, input logic [7:0] d);
        xfer({idx, 4'h0}, d);
    endtask
    task rdc(input logic [3:0] idx, input logic [7:0] e, input string nm);
        xfer({idx, 4'h8}, 8'h00);
        chk(nm, e, rv);
    endtask
    task frames(input int n);
        repeat (n * 256) @(posedge clk_sys);
    endtask
    task t_reset;
        wr(4'ha, 8'hff);
        for (int i = 1; i <= 10; i++) rdc(i[3:0], (i == 2) ? 8'ha5 : 8'h00, "reset or unmapped");
        $display("test reset done");
    endtask
    task t_route;
        wr(`CVRC_IDX_ROUTING, 8'ha0);
        chk("route", 8'h80, {mic, txe, ste, aux, gls, gep, rls, rep});
        wr(`CVRC_IDX_ROUTING, 8'h7f);
        chk("route", 8'h7f, {mic, txe, ste, aux, gls, gep, rls, rep});
        wr(`CVRC_IDX_ROUTING, 8'h55);
        chk("route", 8'h55, {mic, txe, ste, aux, gls, gep, rls, rep});
        rdc(`CVRC_IDX_ROUTING, 8'h55, "routing_reg");
        $display("test route done");
    endtask
    task t_gain;
        wr(`CVRC_IDX_TX_GAIN, 8'h5a);
        wr(`CVRC_IDX_RX_GAIN, 8'h3c);
        wr(`CVRC_IDX_GEN_CTRL, 8'hc9);
        chk("tx gain", 8'h5a, {tg, sa});
        chk("rx gain", 8'h3c, {eg, lg});
        chk("gen ctrl", 8'hc9, {ga, gae, gbe, sine, g2t});
        rdc(`CVRC_IDX_GEN_CTRL, 8'hc9, "gen_ctrl_reg");
        $display("test gain done");
    endtask
    task t_gen;
        wr(`CVRC_IDX_GEN_A_FREQ, 8'h20);
        wr(`CVRC_IDX_GEN_B_FREQ, 8'h9b);
        wr(`CVRC_IDX_GEN_CTRL, 8'h08);
        chk("b phase idle", 10'h000, pb);
        wr(`CVRC_IDX_GEN_CTRL, 8'h0e);
        @(negedge clk_sys);
        p0 = pa;
        p1 = pb;
        repeat (`CVRC_SAMPLE_DIV) @(negedge clk_sys);
        chk("a step", 10'h020, pa - p0);
        chk("b step", 10'h09b, pb - p1);
        @(posedge clk_sys);
        $display("test gen done");
    endtask
    task t_pcm;
        enc <= 8'h3c;
        wr(`CVRC_IDX_CHANNEL_CTRL, 8'h04);
        frames(2);
        chk("dec", 8'ha5, last_dec);
        chk("pcm out", 8'h3c, rxw);
        rdc(`CVRC_IDX_RX_BYTE, 8'ha5, "rx_byte_reg");
        wr(`CVRC_IDX_TX_BYTE, 8'h96);
        wr(`CVRC_IDX_CHANNEL_CTRL, 8'h0c);
        frames(2);
        chk("pcm out", 8'h96, rxw);
        wr(`CVRC_IDX_RX_BYTE, 8'h5e);
        wr(`CVRC_IDX_CHANNEL_CTRL, 8'h14);
        frames(2);
        chk("dec", 8'h5e, last_dec);
        rdc(`CVRC_IDX_RX_BYTE, 8'ha5, "rx_byte_reg");
        wr(`CVRC_IDX_CHANNEL_CTRL, 8'h00);
        oe_seen <= 1'b0;
        last_dec <= 8'h00;
        frames(2);
        chk("oe", 8'h00, oe_seen);
        chk("dec", 8'h00, last_dec);
        $display("test pcm done");
    endtask
    task t_slot;
        gci <= 1'b1;
        slot <= 8'h10;
        enc <= 8'hc3;
        wr(`CVRC_IDX_CHANNEL_CTRL, 8'h06);
        frames(1);
        last_dec <= 8'h00;
        frames(2);
        chk("gci out", 8'hc3, rxw);
        chk("gci dec", 8'ha5, last_dec);
        gci <= 1'b0;
        fmt2 <= 1'b1;
        slot <= 8'h0a;
        enc <= 8'h69;
        wr(`CVRC_IDX_CHANNEL_CTRL, 8'h07);
        frames(1);
        last_dec <= 8'h00;
        frames(2);
        chk("b2 out", 8'h69, rxw);
        chk("b2 dec", 8'ha5, last_dec);
        $display("test slot done");
    endtask
    task t_buf;
        fmt2 <= 1'b0;
        slot <= 8'h00;
        wr(`CVRC_IDX_CHANNEL_CTRL, 8'h04);
        rdy <= 1'b0;
        frames(3);
        while (far.cnt !== 8'h80) @(posedge clk_sys);
        chk("buf head", 8'ha5, dbyte);
        rdy <= 1'b1;
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk("buf second", 10'h2a5, {dval, 1'b0, dbyte});
        @(posedge clk_sys);
        rdy <= 1'b0;
        @(negedge clk_sys);
        chk("buf empty", 8'h00, dval);
        @(posedge clk_sys);
        rdy <= 1'b1;
        $display("test buffer done");
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        t_reset();
        t_route();
        t_gain();
        t_gen();
        t_pcm();
        t_slot();
        t_buf();
        tally_and_finish();
    end
endmodule
`default_nettype wire
